/* verilog/mot_pkg.sv */
// Shared constants and types for the motor overload thermal model
package mot_pkg;
   // Clock and tick timing
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_S = 1000 / TICK_MS;
   // Trip curve constant in seconds
   localparam int CURVE_SECONDS = 35;
   localparam logic [5:0] MAX_CLASS = 6'h28;
   // Cooling time setting is in minutes, five time constants per setting
   localparam int COOL_TAUS = 5;
   localparam int COOL_TICKS_PER_MIN = 60 * TICKS_PER_S / COOL_TAUS;
   // Content is a fraction, full scale at 2^FRAC
   localparam int FRAC = 24;
   localparam int CW = 25;
   localparam logic [CW-1:0] CONTENT_ONE = 25'h1000000;
   localparam int PCT = 100;
   localparam int DW = 52;
   localparam logic [8:0] DERATE_UNITY = 9'h100;
   localparam int DERATE_SHIFT = 8;
   // Register byte addresses
   localparam logic [7:0] A_RATED = 8'h00;
   localparam logic [7:0] A_RATIO = 8'h04;
   localparam logic [7:0] A_CLASS = 8'h08;
   localparam logic [7:0] A_LEVEL = 8'h0c;
   localparam logic [7:0] A_CTRL = 8'h10;
   localparam logic [7:0] A_CONTENT = 8'h14;
   localparam logic [7:0] A_STATE = 8'h18;
   localparam logic [7:0] A_INT_STAT = 8'h1c;
   localparam logic [7:0] A_INT_MASK = 8'h20;
   // Field positions
   localparam int F_HC = 8;
   localparam int F_RUNCLS = 8;
   localparam int F_INDEP = 16;
   localparam int F_LOCK = 8;
   localparam int F_COOL = 16;
   // Interrupt bits
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_TRIP = 1;
   localparam int IRQ_RELEASE = 2;
   localparam int NIRQ = 3;
   // Reset values
   localparam logic [11:0] RST_RATED = 12'h064;
   localparam logic [7:0] RST_SF = 8'h64;
   localparam logic [7:0] RST_HC = 8'h3c;
   localparam logic [5:0] RST_CLASS = 6'h0a;
   localparam logic [6:0] RST_ALARM = 7'h5a;
   localparam logic [6:0] RST_LOCK = 7'h0f;
   localparam logic [7:0] RST_COOL = 8'h1e;

   // Software settings
   typedef struct packed {
      logic [11:0] rated_current_setting;
      logic [7:0] service_factor_setting;
      logic [7:0] hot_cold_ratio_setting;
      logic [5:0] starting_class_setting;
      logic [5:0] running_class_setting;
      logic independent_start_run_enable;
      logic [6:0] alarm_level_setting;
      logic [6:0] lockout_level_setting;
      logic [7:0] cooling_time_setting;
      logic controlled_stop_enable;
   } mot_settings_t;

   // Update sequence states
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_STEADY = 2'b01,
      PH_RATE = 2'b10,
      PH_APPLY = 2'b11
   } mot_phase_t;

   // Fault stop states
   typedef enum logic [1:0] {
      FS_NORMAL = 2'b00,
      FS_DECEL = 2'b01,
      FS_LOCKED = 2'b10
   } mot_fault_t;
endpackage : mot_pkg

/* verilog/mot_overload.sv */
// I-squared-t motor overload thermal model with register port
// How it works
// - Heating accumulates only when current exceeds rated current times service factor
// - No trip is declared while current stays at or below pickup
// - Class N trips in N seconds at six times rated current
// - Trip time is 35 times class over squared derated current minus one
// - Classes 1 to 40 in steps of one are selectable
// - Separate start and run classes; class zero disables that phase
// - Present thermal content is readable on a port and a register
// - Alarm is raised once content reaches the alarm level
// - Alarm drives a relay output warning of an impending trip
// - Content reaching full scale trips and stops the motor
// - With controlled stop enabled, deceleration runs before the final stop
// - Per-tick integration keeps trip time within tolerance
// - After a trip, starts are refused until content falls below lockout
// - Below pickup, content moves exponentially toward the hot/cold steady value
// - Start class during starting, run class afterwards, content kept across
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module mot_overload #(
   parameter int TICK_CYCLES = mot_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Motor measurement and sequencing
   input wire logic [11:0] current_i,
   input wire logic [8:0] derate_i,
   input wire logic starting_i,
   input wire logic start_request_i,
   input wire logic decel_done_i,
   // Protection outputs
   output logic [mot_pkg::CW-1:0] thermal_content_o,
   output logic alarm_o,
   output logic trip_o,
   output logic decel_request_o,
   output logic stop_o,
   output logic start_permit_o,
   output logic irq_o
);

   typedef struct packed {
      mot_pkg::mot_settings_t cfg;
      logic [mot_pkg::NIRQ-1:0] int_stat;
      logic [mot_pkg::NIRQ-1:0] int_mask;
      logic [31:0] rdata;
      logic [31:0] tick_cnt;
      mot_pkg::mot_phase_t ph;
      mot_pkg::mot_fault_t fs;
      logic [mot_pkg::DW-1:0] num;
      logic [mot_pkg::DW-1:0] den;
      logic [mot_pkg::DW-1:0] quo;
      logic [mot_pkg::DW:0] rem;
      logic [5:0] cnt;
      logic heat;
      logic active;
      logic [mot_pkg::CW-1:0] ss;
      logic [mot_pkg::CW-1:0] content;
      logic alarm;
   } mot_state_t;

   mot_state_t s;
   mot_state_t next_s;

   // Derived operating values
   logic [20:0] fla_derated;
   logic [12:0] eff_fla;
   logic [25:0] eff_sq;
   logic [23:0] cur_sq;
   logic [19:0] pickup_lhs;
   logic [19:0] pickup_rhs;
   logic over_pickup;
   logic [5:0] cls;
   logic [mot_pkg::DW:0] rem_sh;
   logic [mot_pkg::CW-1:0] q_sat;
   logic [mot_pkg::CW-1:0] diff;
   logic [mot_pkg::CW-1:0] step;
   logic [mot_pkg::CW:0] sum;
   logic [31:0] content_pct;
   logic [31:0] alarm_ref;
   logic [31:0] lock_ref;
   logic alarm_now;
   logic below_lock;
   logic [mot_pkg::NIRQ-1:0] ev;

   // Class limited to the selectable range
   function automatic logic [5:0] clamp_class(input logic [5:0] c);
      clamp_class = (c > mot_pkg::MAX_CLASS) ? mot_pkg::MAX_CLASS : c;
   endfunction : clamp_class

   // Percent setting placed on the content scale
   function automatic logic [31:0] pct_level(input logic [6:0] p);
      pct_level = {25'h0, p} << mot_pkg::FRAC;
   endfunction : pct_level

   // Effective rated current with imbalance derate applied
   always_comb begin
      fla_derated = s.cfg.rated_current_setting * derate_i;
      eff_fla = fla_derated[20:8];
      if (eff_fla == 13'h0) begin
         eff_fla = 13'h1;
      end
      eff_sq = eff_fla * eff_fla;
      cur_sq = current_i * current_i;
   end

   // Pickup is rated current times service factor, not derated
   assign pickup_lhs = current_i * 8'(mot_pkg::PCT);
   assign pickup_rhs = s.cfg.rated_current_setting * s.cfg.service_factor_setting;
   assign over_pickup = pickup_lhs > pickup_rhs;

   // Class for the present phase of the motor
   always_comb begin
      if (s.cfg.independent_start_run_enable && starting_i) begin
         cls = clamp_class(s.cfg.starting_class_setting);
      end else begin
         cls = clamp_class(s.cfg.running_class_setting);
      end
   end

   // Level comparisons on the content scale
   assign content_pct = s.content * 7'(mot_pkg::PCT);
   assign alarm_ref = pct_level(s.cfg.alarm_level_setting);
   assign lock_ref = pct_level(s.cfg.lockout_level_setting);
   assign alarm_now = content_pct >= alarm_ref;
   assign below_lock = content_pct < lock_ref;

   // Divider step and result shaping
   always_comb begin
      rem_sh = {s.rem[mot_pkg::DW-1:0], s.num[mot_pkg::DW-1]};
      if (s.quo > {27'h0, mot_pkg::CONTENT_ONE}) begin
         q_sat = mot_pkg::CONTENT_ONE;
      end else begin
         q_sat = s.quo[mot_pkg::CW-1:0];
      end
      diff = (s.ss > s.content) ? s.ss - s.content : s.content - s.ss;
      step = (q_sat > diff) ? diff : q_sat;
      sum = {1'b0, s.content} + {1'b0, q_sat};
   end

   // Next state
   always_comb begin
      next_s = s;
      ev = '0;
      next_s.rdata = 32'h0;
      // Register writes
      if (wr_i) begin
         case (addr_i)
            mot_pkg::A_RATED: begin
               next_s.cfg.rated_current_setting = wdata_i[11:0];
            end
            mot_pkg::A_RATIO: begin
               next_s.cfg.service_factor_setting = wdata_i[7:0];
               next_s.cfg.hot_cold_ratio_setting = wdata_i[mot_pkg::F_HC +: 8];
            end
            mot_pkg::A_CLASS: begin
               next_s.cfg.starting_class_setting = wdata_i[5:0];
               next_s.cfg.running_class_setting = wdata_i[mot_pkg::F_RUNCLS +: 6];
               next_s.cfg.independent_start_run_enable = wdata_i[mot_pkg::F_INDEP];
            end
            mot_pkg::A_LEVEL: begin
               next_s.cfg.alarm_level_setting = wdata_i[6:0];
               next_s.cfg.lockout_level_setting = wdata_i[mot_pkg::F_LOCK +: 7];
               next_s.cfg.cooling_time_setting = wdata_i[mot_pkg::F_COOL +: 8];
            end
            mot_pkg::A_CTRL: begin
               next_s.cfg.controlled_stop_enable = wdata_i[0];
            end
            mot_pkg::A_INT_MASK: begin
               next_s.int_mask = wdata_i[mot_pkg::NIRQ-1:0];
            end
            default: begin
            end
         endcase
      end
      // Register reads, data one cycle later
      if (rd_i) begin
         case (addr_i)
            mot_pkg::A_RATED: next_s.rdata = {20'h0, s.cfg.rated_current_setting};
            mot_pkg::A_RATIO: begin
               next_s.rdata = {16'h0, s.cfg.hot_cold_ratio_setting, s.cfg.service_factor_setting};
            end
            mot_pkg::A_CLASS: begin
               next_s.rdata = {15'h0, s.cfg.independent_start_run_enable, 2'h0,
                               s.cfg.running_class_setting, 2'h0, s.cfg.starting_class_setting};
            end
            mot_pkg::A_LEVEL: begin
               next_s.rdata = {8'h0, s.cfg.cooling_time_setting, 1'b0, s.cfg.lockout_level_setting,
                               1'b0, s.cfg.alarm_level_setting};
            end
            mot_pkg::A_CTRL: next_s.rdata = {31'h0, s.cfg.controlled_stop_enable};
            mot_pkg::A_CONTENT: next_s.rdata = {7'h0, s.content};
            mot_pkg::A_STATE: next_s.rdata = {28'h0, s.fs, s.heat, s.alarm};
            mot_pkg::A_INT_STAT: begin
               next_s.rdata = {29'h0, s.int_stat};
               next_s.int_stat = '0;
            end
            mot_pkg::A_INT_MASK: next_s.rdata = {29'h0, s.int_mask};
            default: next_s.rdata = 32'h0;
         endcase
      end
      // Periodic tick
      if (s.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         next_s.tick_cnt = 32'h0;
      end else begin
         next_s.tick_cnt = s.tick_cnt + 32'h1;
      end
      // Update sequence, one pass per tick
      case (s.ph)
         mot_pkg::PH_IDLE: begin
            if (s.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
               next_s.ph = mot_pkg::PH_STEADY;
               next_s.active = cls != 6'h0;
               next_s.heat = over_pickup && (cls != 6'h0);
               // Steady value: hot/cold ratio times derated current ratio
               next_s.num = 52'(({20'h0, s.cfg.hot_cold_ratio_setting} * current_i) << mot_pkg::FRAC);
               next_s.den = 52'(eff_fla * 7'(mot_pkg::PCT));
               next_s.rem = '0;
               next_s.quo = '0;
               next_s.cnt = 6'(mot_pkg::DW);
            end
         end
         mot_pkg::PH_STEADY, mot_pkg::PH_RATE: begin
            next_s.num = s.num << 1;
            if (rem_sh >= {1'b0, s.den}) begin
               next_s.rem = rem_sh - {1'b0, s.den};
               next_s.quo = {s.quo[mot_pkg::DW-2:0], 1'b1};
            end else begin
               next_s.rem = rem_sh;
               next_s.quo = {s.quo[mot_pkg::DW-2:0], 1'b0};
            end
            next_s.cnt = s.cnt - 6'h1;
            if (s.cnt == 6'h1) begin
               next_s.rem = '0;
               next_s.cnt = 6'(mot_pkg::DW);
               if (s.ph == mot_pkg::PH_STEADY) begin
                  next_s.ph = mot_pkg::PH_RATE;
                  next_s.ss = (next_s.quo > {27'h0, mot_pkg::CONTENT_ONE}) ?
                              mot_pkg::CONTENT_ONE : next_s.quo[mot_pkg::CW-1:0];
                  next_s.quo = '0; // Rate divide starts from an empty quotient
                  if (s.heat) begin
                     // Per tick share of 35*class/(r^2-1) seconds
                     next_s.num = 52'((cur_sq - eff_sq[23:0]) << mot_pkg::FRAC);
                     if ({2'h0, cur_sq} <= eff_sq) begin
                        next_s.num = '0;
                     end
                     next_s.den = 52'(eff_sq * 32'(cls * 6'(mot_pkg::CURVE_SECONDS))
                                      * 7'(mot_pkg::TICKS_PER_S));
                  end else begin
                     // Exponential step toward the steady value
                     next_s.num = 52'(next_s.ss > s.content ? next_s.ss - s.content
                                                             : s.content - next_s.ss);
                     next_s.den = 52'(s.cfg.cooling_time_setting * 11'(mot_pkg::COOL_TICKS_PER_MIN));
                     if (s.cfg.cooling_time_setting == 8'h0) begin
                        next_s.den = 52'h1;
                     end
                  end
               end else begin
                  // Final quotient is kept for the apply step
                  next_s.ph = mot_pkg::PH_APPLY;
               end
            end
         end
         mot_pkg::PH_APPLY: begin
            next_s.ph = mot_pkg::PH_IDLE;
            if (s.heat) begin
               next_s.content = sum > {1'b0, mot_pkg::CONTENT_ONE} ?
                                mot_pkg::CONTENT_ONE : sum[mot_pkg::CW-1:0];
            end else if (s.ss > s.content) begin
               next_s.content = s.content + step;
            end else begin
               next_s.content = s.content - step;
            end
         end
         default: next_s.ph = mot_pkg::PH_IDLE;
      endcase
      // Alarm tracks content against alarm level
      next_s.alarm = alarm_now;
      ev[mot_pkg::IRQ_ALARM] = alarm_now && !s.alarm;
      // Trip and fault stop sequence
      case (s.fs)
         mot_pkg::FS_NORMAL: begin
            if (s.content >= mot_pkg::CONTENT_ONE && s.heat && s.active && over_pickup) begin
               ev[mot_pkg::IRQ_TRIP] = 1'b1;
               next_s.fs = s.cfg.controlled_stop_enable ? mot_pkg::FS_DECEL : mot_pkg::FS_LOCKED;
            end
         end
         mot_pkg::FS_DECEL: begin
            if (decel_done_i) begin
               next_s.fs = mot_pkg::FS_LOCKED;
            end
         end
         mot_pkg::FS_LOCKED: begin
            if (below_lock) begin
               ev[mot_pkg::IRQ_RELEASE] = 1'b1;
               next_s.fs = mot_pkg::FS_NORMAL;
            end
         end
         default: next_s.fs = mot_pkg::FS_NORMAL;
      endcase
      // Events set sticky bits, set wins over read clear
      next_s.int_stat = next_s.int_stat | ev;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s <= '0;
         s.cfg.rated_current_setting <= mot_pkg::RST_RATED;
         s.cfg.service_factor_setting <= mot_pkg::RST_SF;
         s.cfg.hot_cold_ratio_setting <= mot_pkg::RST_HC;
         s.cfg.starting_class_setting <= mot_pkg::RST_CLASS;
         s.cfg.running_class_setting <= mot_pkg::RST_CLASS;
         s.cfg.alarm_level_setting <= mot_pkg::RST_ALARM;
         s.cfg.lockout_level_setting <= mot_pkg::RST_LOCK;
         s.cfg.cooling_time_setting <= mot_pkg::RST_COOL;
         s.ph <= mot_pkg::PH_IDLE;
         s.fs <= mot_pkg::FS_NORMAL;
      end else begin
         s <= next_s;
      end
   end

   // Outputs
   assign rdata_o = s.rdata;
   assign thermal_content_o = s.content;
   assign alarm_o = s.alarm;
   assign trip_o = s.fs != mot_pkg::FS_NORMAL;
   assign decel_request_o = s.fs == mot_pkg::FS_DECEL;
   assign stop_o = s.fs == mot_pkg::FS_LOCKED;
   assign start_permit_o = start_request_i && (s.fs == mot_pkg::FS_NORMAL);
   assign irq_o = |(s.int_stat & s.int_mask);

endmodule : mot_overload

/* tb/mot_overload_chk.sv */
// Port checker for the overload thermal model
`timescale 1ns/1ps
module mot_overload_chk #(
   parameter int TICK_CYCLES = 200
) (
   // Clock, reset and register port
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   // Sequencing and protection
   input wire logic start_request_i,
   input wire logic decel_done_i,
   input wire logic [mot_pkg::CW-1:0] thermal_content_o,
   input wire logic trip_o,
   input wire logic decel_request_o,
   input wire logic stop_o,
   input wire logic start_permit_o
);
   int gap;
   logic seen;
   logic [mot_pkg::CW-1:0] last_c;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Cycles since the content last moved
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gap <= 0;
         seen <= 1'b0;
         last_c <= '0;
      end else begin
         last_c <= thermal_content_o;
         gap <= (thermal_content_o != last_c) ? 0 : gap + 1;
         seen <= seen | (thermal_content_o != last_c);
      end
   end
   // Stop profile hand-back
   sequence decel_finish_s;
      decel_request_o && decel_done_i;
   endsequence
   sequence final_stop_s;
      ##[1:3] (stop_o && !decel_request_o);
   endsequence
   content_sat_a: assert property (thermal_content_o <= mot_pkg::CONTENT_ONE)
      else $error("content above full scale");
   tick_spacing_a: assert property ((thermal_content_o != last_c) && seen |-> gap >= TICK_CYCLES - 2)
      else $error("content moved between ticks");
   trip_full_a: assert property ($rose(trip_o) |->
      ($past(thermal_content_o) == mot_pkg::CONTENT_ONE || thermal_content_o == mot_pkg::CONTENT_ONE))
      else $error("trip without full content");
   trip_action_a: assert property ($rose(trip_o) |-> ##[0:2] (decel_request_o || stop_o))
      else $error("trip did not stop the motor");
   stop_excl_a: assert property (!(decel_request_o && stop_o))
      else $error("decel and stop together");
   decel_end_a: assert property (decel_finish_s |-> final_stop_s)
      else $error("no stop after profile end");
   start_block_a: assert property (start_permit_o == (start_request_i && !trip_o))
      else $error("start permit wrong");
   read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its cycle");
   content_read_a: assert property (rd_i && addr_i == mot_pkg::A_CONTENT |=>
      rdata_o == {7'h0, $past(thermal_content_o)})
      else $error("content read wrong");
endmodule : mot_overload_chk

bind mot_overload mot_overload_chk #(.TICK_CYCLES(TICK_CYCLES)) mot_overload_chk_i (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .start_request_i(start_request_i),
   .decel_done_i(decel_done_i), .thermal_content_o(thermal_content_o), .trip_o(trip_o),
   .decel_request_o(decel_request_o), .stop_o(stop_o), .start_permit_o(start_permit_o));

/* tb/mot_sequencer.sv */
// Model of current sensing and the run/stop sequencer
`timescale 1ns/1ps
module mot_sequencer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bench demands
   input wire logic [11:0] cur_i,
   input wire logic [8:0] der_i,
   input wire logic start_phase_i,
   input wire logic run_i,
   input wire logic [7:0] decel_len_i,
   // Block side
   input wire logic decel_request_i,
   output logic [11:0] current_o,
   output logic [8:0] derate_o,
   output logic starting_o,
   output logic start_request_o,
   output logic decel_done_o
);
   logic [7:0] cnt;
   // Follow the demands; time the stop profile
   always_ff @(posedge clk_i) begin
      current_o <= cur_i;
      derate_o <= der_i;
      starting_o <= start_phase_i;
      start_request_o <= run_i;
      if (!rst_n_i || !decel_request_i) begin
         cnt <= 8'h00;
         decel_done_o <= 1'b0;
      end else if (cnt == decel_len_i) begin
         decel_done_o <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule : mot_sequencer

/* tb/test_mot_overload.sv */
// Self-checking bench for the overload thermal model
`timescale 1ns/1ps
module test_mot_overload;
   localparam int TICK = 200;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [11:0] cur = 12'h000;
   logic [8:0] der = 9'h100;
   logic sp = 1'b0;
   logic run = 1'b0;
   logic [7:0] dlen = 8'h00;
   logic [31:0] seed = 32'h3a55663e;
   logic [31:0] d, v, rdata_o;
   logic [11:0] current_i, rated;
   logic [8:0] derate_i;
   logic starting_i, start_request_i, decel_done_i, alarm_o, trip_o, decel_request_o, stop_o, start_permit_o, irq_o;
   logic [mot_pkg::CW-1:0] thermal_content_o;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   int t0, tc, ta;
   real m;
   logic [7:0] ra [7] = '{mot_pkg::A_RATED, mot_pkg::A_RATIO, mot_pkg::A_CLASS, mot_pkg::A_LEVEL,
      mot_pkg::A_CTRL, mot_pkg::A_INT_MASK, 8'h40};
   logic [31:0] rv [7] = '{{20'h0, mot_pkg::RST_RATED}, {16'h0, mot_pkg::RST_HC, mot_pkg::RST_SF},
      {18'h0, mot_pkg::RST_CLASS, 2'h0, mot_pkg::RST_CLASS}, {8'h0, mot_pkg::RST_COOL, 1'b0, mot_pkg::RST_LOCK,
      1'b0, mot_pkg::RST_ALARM}, 32'h0, 32'h0, 32'h0};
   // Clock and cycle count
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   mot_overload #(.TICK_CYCLES(TICK)) mot_overload_i (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .current_i(current_i), .derate_i(derate_i),
      .starting_i(starting_i), .start_request_i(start_request_i), .decel_done_i(decel_done_i),
      .thermal_content_o(thermal_content_o), .alarm_o(alarm_o), .trip_o(trip_o),
      .decel_request_o(decel_request_o), .stop_o(stop_o), .start_permit_o(start_permit_o), .irq_o(irq_o));
   mot_sequencer mot_sequencer_i (.clk_i(clk), .rst_n_i(rst_n), .cur_i(cur), .der_i(der), .start_phase_i(sp),
      .run_i(run), .decel_len_i(dlen), .decel_request_i(decel_request_o), .current_o(current_i),
      .derate_o(derate_i), .starting_o(starting_i), .start_request_o(start_request_i), .decel_done_o(decel_done_i));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Ticks to trip from the curve
   function automatic real exp_ticks(input real i, input real e, input int cls);
      return 35.0 * cls * mot_pkg::TICKS_PER_S / ((i / e) ** 2 - 1.0);
   endfunction : exp_ticks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk);
      addr <= a;
      wdata <= dat;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] dat);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 dat = rdata_o;
   endtask : rd_reg
   task automatic wait_smp(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_smp
   task automatic stop_test();
      $display("Counts: %0d mismatches, %0d checks", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   // Hang guard
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 7; k++) begin
         rd_reg(ra[k], d);
         chk(d, rv[k], "reset value");
      end
      v = rnd();
      wr_reg(mot_pkg::A_RATED, v);
      rd_reg(mot_pkg::A_RATED, d);
      chk(d, {20'h0, v[11:0]}, "rated readback");
      wr_reg(mot_pkg::A_CONTENT, v);
      rd_reg(mot_pkg::A_CONTENT, d);
      chk(d, 32'h0, "content is read-only");
      wr_reg(8'h40, v);
      rd_reg(8'h40, d);
      chk(d, 32'h0, "unmapped");
      // Pickup boundary at service factor 1.15
      wr_reg(mot_pkg::A_RATED, 32'd100);
      wr_reg(mot_pkg::A_RATIO, 32'h73);
      wr_reg(mot_pkg::A_LEVEL, 32'h000f32);
      wr_reg(mot_pkg::A_CLASS, 32'h0101);
      @(posedge clk);
      cur <= 12'd115;
      wait_smp(4 * TICK);
      chk({7'h0, thermal_content_o}, 32'h0, "no heat at pickup");
      chk({31'h0, trip_o}, 32'h0, "no trip at pickup");
      @(posedge clk);
      cur <= 12'd116;
      wait_smp(3 * TICK);
      chk({31'h0, thermal_content_o != 0}, 32'h1, "heat above pickup");
      // Steady state at full load, ratio 60 percent
      wr_reg(mot_pkg::A_RATIO, 32'h3c64);
      @(posedge clk);
      cur <= 12'd100;
      wait_smp(3 * TICK);
      m = real'(thermal_content_o) - 0.6 * 16777216.0;
      chk({31'h0, m < 256.0 && m > -256.0}, 32'h1, "steady state");
      wr_reg(mot_pkg::A_RATIO, 32'h64);
      @(posedge clk);
      cur <= 12'h000;
      wait_smp(3 * TICK);
      chk({7'h0, thermal_content_o}, 32'h0, "cooled");
      // Trips: plain run class, then start class with derate and controlled stop
      for (int k = 0; k < 2; k++) begin
         rated = 12'd50 + 12'(rnd() % 100);
         wr_reg(mot_pkg::A_RATED, {20'h0, rated});
         wr_reg(mot_pkg::A_CLASS, k ? 32'h10001 : 32'h100);
         wr_reg(mot_pkg::A_CTRL, 32'(k));
         @(posedge clk);
         sp <= k[0];
         dlen <= k ? 8'h3c : 8'h00;
         der <= k ? 9'h080 : 9'h100;
         cur <= k ? 12'(3 * rated) : 12'(6 * rated);
         t0 = cyc;
         tc = 0;
         ta = 0;
         for (int n = 0; n < 30000 && trip_o !== 1'b1; n++) begin
            wait_smp(1);
            if (tc == 0 && {7'h0, thermal_content_o} * 32'd100 >= 32'd50 << 24) tc = cyc;
            if (ta == 0 && alarm_o === 1'b1) ta = cyc;
         end
         m = real'(cyc - t0) / TICK - exp_ticks(real'(cur), real'(rated) * der / 256.0, 1);
         chk({31'h0, m < 22.0 && m > -22.0}, 32'h1, "trip time");
         chk({31'h0, tc != 0 && ta >= tc && ta - tc <= 3}, 32'h1, "alarm timing");
         chk({31'h0, irq_o}, 32'h0, "irq masked");
         chk({31'h0, decel_request_o}, 32'(k), "decel profile");
         wait_smp(80);
         chk({31'h0, stop_o}, 32'h1, "final stop");
         rd_reg(mot_pkg::A_STATE, d);
         chk(d, 32'hb, "state locked heating alarm");
         @(posedge clk);
         run <= 1'b1;
         wait_smp(2);
         chk({31'h0, start_permit_o}, 32'h0, "start refused");
         wr_reg(mot_pkg::A_INT_MASK, 32'h7);
         wait_smp(2);
         chk({31'h0, irq_o}, 32'h1, "irq raised");
         rd_reg(mot_pkg::A_INT_STAT, d);
         chk(d, 32'h3, "status alarm and trip");
         wait_smp(2);
         chk({31'h0, irq_o}, 32'h0, "irq cleared");
         @(posedge clk);
         cur <= 12'h000;
         wait_smp(3 * TICK);
         chk({31'h0, stop_o}, 32'h0, "lockout released");
         chk({31'h0, start_permit_o}, 32'h1, "start allowed");
         rd_reg(mot_pkg::A_INT_STAT, d);
         chk(d, 32'h4, "status release");
         wr_reg(mot_pkg::A_INT_MASK, 32'h0);
         @(posedge clk);
         run <= 1'b0;
         sp <= 1'b0;
      end
      // Run class off: overload current must not heat or trip
      @(posedge clk);
      der <= 9'h100;
      cur <= 12'(6 * rated);
      wait_smp(10 * TICK);
      chk({7'h0, thermal_content_o}, 32'h0, "run class off");
      chk({31'h0, trip_o}, 32'h0, "no trip when off");
      stop_test();
   end
endmodule : test_mot_overload
